// File: core/pwmcap_top.v
// capture, run control, fault mapping, capture dma and interrupt enables
// for four pwm submodules with three capture pins each, on an avalon slave
// assumes the waveform generator sits beside this block on sys_clk
//
// Behaviour
// - clearing run stops submodule, zeroes counter
// - one write stops several submodules together
// - setting run starts submodule counting
// - capture event stores submodule counter value
// - capture also stores current cycle number
// - cycle count increments at each modulo reload
// - edge counter counts rising and falling edges
// - edge count compare selectable as trigger
// - three capture pins per submodule, each configurable
// - one-shot capture clears its own enable
// - clearing capture enable halts capture at once
// - software reads live input pin levels
// - each output maps any fault inputs
// - mapped active fault forces output off
// - selectable trigger raises capture dma requests
// - per-source submodule interrupt enables, one read/write word
// - separate compare zero and one interrupts
// - per-fault-pin interrupt enables
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "pwmcap_map.vh"
module pwmcap_top (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [8:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [11:0] cap_pin,
  input wire [3:0] fault_pin,
  input wire [11:0] pwm_in,
  output wire [11:0] pwm_out,
  output wire [3:0] sm_irq,
  output wire fault_irq,
  output wire [3:0] dma_req
);
  integer i;
  integer j;

  // bus side
  reg ack_ff;
  reg [31:0] rdata_ff;
  reg [31:0] rd_mux;
  wire wr_go;
  wire [31:0] wmask;
  wire [31:0] wdm;
  wire [31:0] wr_merge;
  wire is_glb;
  wire glb_ok;
  wire [1:0] smi;
  wire [3:0] wi;
  wire [3:0] sm_dec;
  wire [2:0] pin_dec;
  wire [3:0] sm_w;
  wire is_cfg;
  wire is_val;
  wire [3:0] cfg_ch;
  wire [3:0] val_pin;
  wire [3:0] val_ch;

  // submodule state
  reg [3:0] run_ff;
  reg [63:0] mod_ff;
  reg [63:0] cnt_ff;
  reg [63:0] cyc_ff;
  reg [63:0] cmp0_ff;
  reg [63:0] cmp1_ff;
  reg [7:0] cmpf_ff;
  reg [19:0] irqen_ff;
  reg [3:0] dmaen_ff;
  reg [7:0] dmasrc_ff;
  reg [47:0] fmap_ff;
  reg [3:0] sm_irq_ff;
  reg [3:0] dma_req_ff;
  wire [3:0] reload;
  wire [7:0] cmpf_clr;

  // capture channel state
  reg [11:0] cen_ff;
  reg [11:0] osh_ff;
  reg [23:0] esel_ff;
  reg [11:0] tsrc_ff;
  reg [95:0] ecmp_ff;
  reg [11:0] capf_ff;
  wire [11:0] cap_evt;
  wire [11:0] capf_clr;
  wire [11:0] cfg_wr;
  wire [191:0] capv;
  wire [191:0] capc;
  wire [95:0] ecnt;

  // fault side
  reg [3:0] fltf_ff;
  reg [3:0] flten_ff;
  reg fault_irq_ff;
  reg [11:0] pwm_out_ff;
  wire [11:0] kill;
  wire [15:0] sync_o;
  wire [11:0] pin_s;
  wire [3:0] flt_s;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  pwmcap_sync #(.W(16)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({fault_pin, cap_pin}),
    .sync_out(sync_o)
  );
  assign pin_s = sync_o[11:0];
  assign flt_s = sync_o[15:12];

  // ---------------------------------------------------------------------------
  // avalon decode
  // ---------------------------------------------------------------------------
  // one wait state: read data is registered, so every access takes two cycles
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign wr_go = avs_write & ack_ff & clk_en;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdm = avs_writedata & wmask;
  // unwritten byte lanes keep the current register contents
  assign wr_merge = (rd_mux & ~wmask) | wdm;
  assign is_glb = ~avs_address[`PWMCAP_SM_REGION_BIT];
  assign glb_ok = is_glb & (avs_address[7:6] == 2'h0);
  assign smi = avs_address[7:6];
  assign wi = avs_address[5:2];
  assign sm_dec = 4'h1 << smi;
  assign pin_dec = 3'h1 << wi[1:0];
  assign sm_w = {4{wr_go & ~is_glb}} & sm_dec;
  assign is_cfg = (wi >= `PWMCAP_S_CFG0) & (wi <= `PWMCAP_S_CFG2);
  assign is_val = (wi >= `PWMCAP_S_COMPARE_VALUE_ZERO) & (wi <= `PWMCAP_S_VAL2);
  assign cfg_ch = ({2'h0, smi} * 4'h3) + {2'h0, wi[1:0]};
  assign val_pin = wi - `PWMCAP_S_COMPARE_VALUE_ZERO;
  assign val_ch = ({2'h0, smi} * 4'h3) + val_pin;

  // read mux; unmapped words read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (is_glb) begin
      if (glb_ok) begin
        case (wi)
          `PWMCAP_G_RUN: rd_mux = {28'h0, run_ff};
          `PWMCAP_G_FSTAT: rd_mux = {24'h0, flt_s, fltf_ff};
          `PWMCAP_G_FIEN: rd_mux = {28'h0, flten_ff};
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    end else if (is_cfg) begin
      rd_mux = {8'h0, ecnt[cfg_ch*8 +: 8], ecmp_ff[cfg_ch*8 +: 8], 3'h0, tsrc_ff[cfg_ch],
                esel_ff[cfg_ch*2 +: 2], osh_ff[cfg_ch], cen_ff[cfg_ch]};
    end else if (is_val) begin
      // value and cycle share one word so a single read is coherent
      rd_mux = {capc[val_ch*16 +: 16], capv[val_ch*16 +: 16]};
    end else begin
      case (wi)
        `PWMCAP_S_MOD: rd_mux = {16'h0, mod_ff[smi*16 +: 16]};
        `PWMCAP_S_COUNT: rd_mux = {16'h0, cnt_ff[smi*16 +: 16]};
        `PWMCAP_S_CMP0: rd_mux = {16'h0, cmp0_ff[smi*16 +: 16]};
        `PWMCAP_S_CMP1: rd_mux = {16'h0, cmp1_ff[smi*16 +: 16]};
        `PWMCAP_S_STAT: rd_mux = {21'h0, pin_s[smi*3 +: 3], 3'h0,
                                  capf_ff[smi*3 +: 3], cmpf_ff[smi*2 +: 2]};
        `PWMCAP_S_IEN: rd_mux = {27'h0, irqen_ff[smi*5 +: 5]};
        `PWMCAP_S_DMA: rd_mux = {29'h0, dmasrc_ff[smi*2 +: 2], dmaen_ff[smi]};
        `PWMCAP_S_FMAP: rd_mux = {20'h0, fmap_ff[smi*12 +: 12]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // per-channel and per-submodule wiring
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_ch
      assign cfg_wr[g] = wr_go & ~is_glb & is_cfg & sm_dec[g/3] & pin_dec[g%3];
      assign capf_clr[g] = sm_w[g/3] & (wi == `PWMCAP_S_STAT) &
                           wdm[`PWMCAP_STAT_CAPF_LO + g%3];
      // mapped active fault drives the output to its off level
      assign kill[g] = |(fmap_ff[g*4 +: 4] & flt_s);
      pwmcap_capch u_cap (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cap_en(cen_ff[g]),
        .edge_sel(esel_ff[g*2 +: 2]),
        .trig_src(tsrc_ff[g]),
        .edge_cmp(ecmp_ff[g*8 +: 8]),
        .pin_lvl(pin_s[g]),
        .sm_count(cnt_ff[(g/3)*16 +: 16]),
        .sm_cycle(cyc_ff[(g/3)*16 +: 16]),
        .cap_evt(cap_evt[g]),
        .cap_value_ff(capv[g*16 +: 16]),
        .cap_cycle_ff(capc[g*16 +: 16]),
        .edge_cnt_ff(ecnt[g*8 +: 8])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : g_sm
      assign reload[g] = run_ff[g] & (cnt_ff[g*16 +: 16] == mod_ff[g*16 +: 16]);
      assign cmpf_clr[g*2 +: 2] = {2{sm_w[g] & (wi == `PWMCAP_S_STAT)}} & wdm[1:0];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // registers and sequential behaviour
  // ---------------------------------------------------------------------------
  // a hardware event in the same cycle as its w1c clear keeps the flag set
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      run_ff <= 4'h0;
      mod_ff <= {4{`PWMCAP_MOD_RST}};
      cnt_ff <= 64'h0;
      cyc_ff <= 64'h0;
      cmp0_ff <= 64'h0;
      cmp1_ff <= 64'h0;
      cmpf_ff <= 8'h00;
      irqen_ff <= 20'h0_0000;
      dmaen_ff <= 4'h0;
      dmasrc_ff <= 8'h00;
      fmap_ff <= 48'h0;
      sm_irq_ff <= 4'h0;
      dma_req_ff <= 4'h0;
      cen_ff <= 12'h000;
      osh_ff <= 12'h000;
      esel_ff <= 24'h00_0000;
      tsrc_ff <= 12'h000;
      ecmp_ff <= 96'h0;
      capf_ff <= 12'h000;
      fltf_ff <= 4'h0;
      flten_ff <= 4'h0;
      fault_irq_ff <= 1'b0;
      pwm_out_ff <= 12'h000;
    end else if (clk_en) begin
      // bus handshake and registered read data
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      if (avs_read && !ack_ff) begin
        rdata_ff <= rd_mux;
      end

      // all run bits come from one word, so starts and stops share an edge
      if (wr_go && glb_ok && wi == `PWMCAP_G_RUN) begin
        run_ff <= wr_merge[3:0];
      end
      if (wr_go && glb_ok && wi == `PWMCAP_G_FIEN) begin
        flten_ff <= wr_merge[3:0];
      end
      fltf_ff <= (fltf_ff & ~({4{wr_go & glb_ok & (wi == `PWMCAP_G_FSTAT)}} & wdm[3:0]))
                 | flt_s;
      fault_irq_ff <= |(fltf_ff & flten_ff);
      pwm_out_ff <= pwm_in & ~kill;

      for (i = 0; i < 4; i = i + 1) begin
        // counter runs only while run is set; clearing run zeroes it
        if (!run_ff[i]) begin
          cnt_ff[i*16 +: 16] <= 16'h0000;
        end else if (reload[i]) begin
          cnt_ff[i*16 +: 16] <= 16'h0000;
          cyc_ff[i*16 +: 16] <= cyc_ff[i*16 +: 16] + 16'h0001;
        end else begin
          cnt_ff[i*16 +: 16] <= cnt_ff[i*16 +: 16] + 16'h0001;
        end
        if (sm_w[i] && wi == `PWMCAP_S_MOD) begin
          mod_ff[i*16 +: 16] <= wr_merge[15:0];
        end
        if (sm_w[i] && wi == `PWMCAP_S_CMP0) begin
          cmp0_ff[i*16 +: 16] <= wr_merge[15:0];
        end
        if (sm_w[i] && wi == `PWMCAP_S_CMP1) begin
          cmp1_ff[i*16 +: 16] <= wr_merge[15:0];
        end
        cmpf_ff[i*2] <= (cmpf_ff[i*2] & ~cmpf_clr[i*2]) |
                        (run_ff[i] & (cnt_ff[i*16 +: 16] == cmp0_ff[i*16 +: 16]));
        cmpf_ff[i*2+1] <= (cmpf_ff[i*2+1] & ~cmpf_clr[i*2+1]) |
                          (run_ff[i] & (cnt_ff[i*16 +: 16] == cmp1_ff[i*16 +: 16]));
        if (sm_w[i] && wi == `PWMCAP_S_IEN) begin
          irqen_ff[i*5 +: 5] <= wr_merge[4:0];
        end
        if (sm_w[i] && wi == `PWMCAP_S_DMA) begin
          dmaen_ff[i] <= wr_merge[`PWMCAP_DMA_EN];
          dmasrc_ff[i*2 +: 2] <= wr_merge[`PWMCAP_DMA_SRC_LO +: 2];
        end
        if (sm_w[i] && wi == `PWMCAP_S_FMAP) begin
          fmap_ff[i*12 +: 12] <= wr_merge[11:0];
        end
        // source bits: cmp0, cmp1, then the three capture flags
        sm_irq_ff[i] <= |({capf_ff[i*3 +: 3], cmpf_ff[i*2 +: 2]} & irqen_ff[i*5 +: 5]);
        // source choice is inert until dma is enabled for the submodule
        dma_req_ff[i] <= dmaen_ff[i] &
          ((((dmasrc_ff[i*2 +: 2] == `PWMCAP_DSRC_CAPTURE) |
             (dmasrc_ff[i*2 +: 2] == `PWMCAP_DSRC_BOTH)) & (|cap_evt[i*3 +: 3])) |
           (((dmasrc_ff[i*2 +: 2] == `PWMCAP_DSRC_RELOAD) |
             (dmasrc_ff[i*2 +: 2] == `PWMCAP_DSRC_BOTH)) & reload[i]));
      end

      for (j = 0; j < 12; j = j + 1) begin
        // one-shot clear beats a software write in the same cycle
        if (cap_evt[j] && osh_ff[j]) begin
          cen_ff[j] <= 1'b0;
        end else if (cfg_wr[j]) begin
          cen_ff[j] <= wr_merge[`PWMCAP_CFG_EN];
        end
        if (cfg_wr[j]) begin
          osh_ff[j] <= wr_merge[`PWMCAP_CFG_ONESHOT];
          esel_ff[j*2 +: 2] <= wr_merge[`PWMCAP_CFG_EDGE_LO +: 2];
          tsrc_ff[j] <= wr_merge[`PWMCAP_CFG_TRIG];
          ecmp_ff[j*8 +: 8] <= wr_merge[`PWMCAP_CFG_ECMP_LO +: 8];
        end
        capf_ff[j] <= (capf_ff[j] & ~capf_clr[j]) | cap_evt[j];
      end
    end
  end

  assign pwm_out = pwm_out_ff;
  assign sm_irq = sm_irq_ff;
  assign fault_irq = fault_irq_ff;
  assign dma_req = dma_req_ff;
endmodule

// File: pkg/pwmcap_map.vh
// register map, field positions and reset values of the capture/fault block
// assumes a 32-bit avalon slave with a 9-bit byte address
`ifndef PWMCAP_MAP_VH
`define PWMCAP_MAP_VH

// ----------------------------------------------------------------------------
// address layout
// ----------------------------------------------------------------------------
`define PWMCAP_SM_REGION_BIT 8
`define PWMCAP_G_RUN 4'h0
`define PWMCAP_G_FSTAT 4'h1
`define PWMCAP_G_FIEN 4'h2
`define PWMCAP_S_MOD 4'h0
`define PWMCAP_S_COUNT 4'h1
`define PWMCAP_S_CMP0 4'h2
`define PWMCAP_S_CMP1 4'h3
`define PWMCAP_S_STAT 4'h4
`define PWMCAP_S_IEN 4'h5
`define PWMCAP_S_DMA 4'h6
`define PWMCAP_S_FMAP 4'h7
`define PWMCAP_S_CFG0 4'h8
`define PWMCAP_S_CFG2 4'ha
`define PWMCAP_S_COMPARE_VALUE_ZERO 4'hb
`define PWMCAP_S_VAL2 4'hd

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PWMCAP_CFG_EN 0
`define PWMCAP_CFG_ONESHOT 1
`define PWMCAP_CFG_EDGE_LO 2
`define PWMCAP_CFG_TRIG 4
`define PWMCAP_CFG_ECMP_LO 8
`define PWMCAP_STAT_CAPF_LO 2
`define PWMCAP_DMA_EN 0
`define PWMCAP_DMA_SRC_LO 1

// ----------------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------------
`define PWMCAP_DSRC_NONE 2'h0
`define PWMCAP_DSRC_CAPTURE 2'h1
`define PWMCAP_DSRC_RELOAD 2'h2
`define PWMCAP_DSRC_BOTH 2'h3
`define PWMCAP_MOD_RST 16'hffff

`endif

// File: core/pwmcap_sync.v
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ns
module pwmcap_sync #(
  parameter W = 16
) (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// File: core/pwmcap_capch.v
// one input capture circuit: edge detect, edge counter, value and cycle latch
// assumes pin_lvl is already synchronised to sys_clk
`timescale 1ns/1ns
module pwmcap_capch (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire cap_en,
  input wire [1:0] edge_sel,
  input wire trig_src,
  input wire [7:0] edge_cmp,
  input wire pin_lvl,
  input wire [15:0] sm_count,
  input wire [15:0] sm_cycle,
  output wire cap_evt,
  output reg [15:0] cap_value_ff,
  output reg [15:0] cap_cycle_ff,
  output reg [7:0] edge_cnt_ff
);
  reg prev_ff;
  wire rise;
  wire fall;
  wire any_edge;
  wire edge_hit;
  wire cmp_hit;
  wire [7:0] nxt_edge_cnt;

  // ---------------------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------------------
  // edge_sel bit 0 picks rising, bit 1 falling; both gives either edge
  assign rise = pin_lvl & ~prev_ff;
  assign fall = ~pin_lvl & prev_ff;
  assign any_edge = rise | fall;
  assign edge_hit = (edge_sel[0] & rise) | (edge_sel[1] & fall);
  assign nxt_edge_cnt = edge_cnt_ff + 8'h01;
  assign cmp_hit = any_edge & (nxt_edge_cnt == edge_cmp);
  // gating by cap_en stops capture in the same cycle that it clears
  assign cap_evt = cap_en & (trig_src ? cmp_hit : edge_hit);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  // prev tracks the pin even while disabled so enabling sees no stale edge
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ff <= 1'b0;
      edge_cnt_ff <= 8'h00;
      cap_value_ff <= 16'h0000;
      cap_cycle_ff <= 16'h0000;
    end else if (clk_en) begin
      prev_ff <= pin_lvl;
      if (cap_en && any_edge) begin
        // compare match restarts the count in edge-counter trigger mode
        edge_cnt_ff <= (trig_src && cmp_hit) ? 8'h00 : nxt_edge_cnt;
      end
      if (cap_evt) begin
        cap_value_ff <= sm_count;
        cap_cycle_ff <= sm_cycle;
      end
    end
  end
endmodule

// File: test/pwmcap_props.sv
// checker for pwmcap_top: bus handshake, read data and output forcing
// assumes it is bound to pwmcap_top and sees only its ports
`timescale 1ns/1ns
module pwmcap_props (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [8:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [11:0] pwm_in,
  input wire [11:0] pwm_out,
  input wire [3:0] fault_pin,
  input wire [3:0] sm_irq,
  input wire fault_irq,
  input wire [3:0] dma_req
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // any pending access
  wire req = avs_read | avs_write;

  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("first access cycle not stalled");
  one_wait_a: assert property (req && avs_waitrequest && clk_en |=> !req || !avs_waitrequest)
    else $error("access stalled beyond one cycle");
  idle_ready_a: assert property (!req |-> !avs_waitrequest)
    else $error("stall without access");
  next_stall_a: assert property (req && !avs_waitrequest && clk_en |=> !req || avs_waitrequest)
    else $error("follow-on access not stalled");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  // unmapped words must read as zero
  unmap_glob_a: assert property (avs_read && avs_waitrequest && !avs_address[8]
    && avs_address[7:2] > 6'h2 |=> avs_readdata == 32'h0)
    else $error("unmapped global word not zero");
  unmap_sub_a: assert property (avs_read && avs_waitrequest && avs_address[8]
    && avs_address[5:2] > 4'hd |=> avs_readdata == 32'h0)
    else $error("unmapped submodule word not zero");
  // a fault may only pull an output low, never raise it
  fault_subset_a: assert property ($past(clk_en) |-> (pwm_out & ~$past(pwm_in)) == 12'h0)
    else $error("output high without waveform high");
  fault_quiet_a: assert property ((fault_pin == 4'h0 && clk_en) [*4] |-> pwm_out == $past(pwm_in))
    else $error("output forced with no fault active");

  dma_seen_c: cover property (dma_req[0]);
  irq_seen_c: cover property ($rose(sm_irq[0]));
  fault_irq_c: cover property ($rose(fault_irq));
  forced_c: cover property ($past(pwm_in[3]) && !pwm_out[3]);
endmodule

bind pwmcap_top pwmcap_props i_props (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_in(pwm_in),
  .pwm_out(pwm_out), .fault_pin(fault_pin), .sm_irq(sm_irq), .fault_irq(fault_irq),
  .dma_req(dma_req));

// File: test/tb.sv
// self-checking bench for pwmcap_top: run, capture, dma, irq, fault
// assumes one wait state per avalon access and a 125 mhz clock
`timescale 1ns/1ns
module tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg clk_en = 1'b1;
  reg [8:0] avs_address = 9'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [11:0] cap_pin = 12'h0;
  reg [3:0] fault_pin = 4'h0;
  reg [11:0] pwm_in = 12'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [11:0] pwm_out;
  wire [3:0] sm_irq;
  wire fault_irq;
  wire [3:0] dma_req;
  integer errors = 0, tests_run = 0, cyc = 0, dma_n = 0, seed = 32'h0564;
  integer i, t, ta, va, d0;
  // behavioural model of submodule 0: run bits and ticks since its start
  reg [3:0] run_m = 4'h0;
  integer tick0 = 0;
  reg [31:0] q, q2;
  reg [11:0] m, exp_out;

  pwmcap_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_pin(cap_pin), .fault_pin(fault_pin),
    .pwm_in(pwm_in), .pwm_out(pwm_out), .sm_irq(sm_irq), .fault_irq(fault_irq),
    .dma_req(dma_req));

  // ---------------------------------------------------------------
  // clock, cycle count, dma pulse count
  // ---------------------------------------------------------------
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dma_req[0] === 1'b1) dma_n <= dma_n + 1;
    // period of four once the modulo is three; frozen while clk_en is low
    if (run_m[0] && clk_en) tick0 <= tick0 + 1;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("Error %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access, held until stall drops; extra edge keeps strobes apart
  task bus(input w, input [8:0] a, input [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    // no cycle count assumed; only the watchdog ends a hang
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    // model run bits change at the edge where the write lands
    if (w && a == 9'h000) run_m <= d[3:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input [8:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [8:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  function [8:0] sa(input integer s, input integer w);
    sa = 9'h100 + 9'(s * 64 + w * 4);
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog, far beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors = errors + 1;
    wrap_up;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(sa(0, 0));
    chk(q, 32'hffff, "mod reset");
    wr(9'h0fc, 32'h1234);
    rd(9'h0fc);
    chk(q, 32'h0, "unmapped");
    rd(sa(2, 15));
    chk(q, 32'h0, "unmapped sm");
    // period of four cycles everywhere; reads land three cycles apart
    for (i = 0; i < 4; i = i + 1) wr(sa(i, 0), 32'h3);
    wr(9'h000, 32'hf);
    repeat (5) @(posedge sys_clk);
    rd(sa(3, 1));
    ta = q;
    rd(sa(3, 1));
    chk(q, (ta + 3) % 4, "count step");
    // a low clock enable must hold the counter where it stood
    clk_en <= 1'b0;
    repeat (7) @(posedge sys_clk);
    clk_en <= 1'b1;
    t = tick0;
    rd(sa(0, 1));
    chk(q, t % 4, "frozen count");
    wr(9'h000, 32'h9);
    rd(sa(1, 1));
    chk(q, 0, "stop sm1");
    rd(sa(2, 1));
    chk(q, 0, "stop sm2");
    wr(9'h000, 32'h1);
    // two captures exactly 101 cycles apart on pin 0 of sm0
    wr(sa(0, 6), 32'h2);
    d0 = dma_n;
    wr(sa(0, 8), 32'hd);
    ta = cyc;
    // model: the pin edge is seen three edges on, past the two sync stages
    va = tick0 + 3;
    cap_pin[0] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(sa(0, 11));
    chk(q, {16'(va / 4), 16'(va % 4)}, "cap first");
    while (cyc != ta + 101) @(posedge sys_clk);
    cap_pin[0] <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rd(sa(0, 11));
    q2 = q;
    t = va + 101;
    chk(q[15:0], t % 4, "cap value");
    chk(q[31:16], t / 4, "cap cycle");
    rd(sa(0, 8));
    chk(q[23:16], 2, "edge count");
    rd(sa(0, 4));
    chk(q[2], 1, "cap flag");
    // disabled capture ignores the pin
    wr(sa(0, 8), 32'hc);
    cap_pin[0] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(sa(0, 11));
    chk(q, q2, "halted value");
    rd(sa(0, 8));
    chk(q[23:16], 2, "halted edges");
    chk(dma_n - d0, 0, "dma gated");
    // one-shot on pin 1 with capture dma on
    wr(sa(0, 6), 32'h3);
    d0 = dma_n;
    wr(sa(0, 9), 32'h7);
    for (i = 0; i < 3; i = i + 1) begin
      cap_pin[1] <= ~cap_pin[1];
      repeat (6) @(posedge sys_clk);
    end
    rd(sa(0, 9));
    chk(q[0], 0, "one-shot off");
    chk(dma_n - d0, 1, "dma capture");
    // every source code, no captures pending
    for (i = 0; i < 4; i = i + 1) begin
      wr(sa(0, 6), 2 * i + 1);
      d0 = dma_n;
      repeat (40) @(posedge sys_clk);
      chk(dma_n != d0, i >= 2, "dma source");
    end
    wr(sa(0, 6), 32'h0);
    // edge counter compare of three fires the capture on pin 2
    wr(sa(0, 4), 32'h1f);
    wr(sa(0, 10), 32'h31d);
    for (i = 1; i <= 3; i = i + 1) begin
      cap_pin[2] <= ~cap_pin[2];
      repeat (6) @(posedge sys_clk);
      rd(sa(0, 4));
      chk(q[4], i == 3, "edge trigger");
    end
    rd(sa(0, 10));
    chk(q[23:16], 0, "edge restart");
    // compare flags and their enables: 1, 2, then none
    wr(sa(0, 2), 32'h1);
    // compare one lies beyond the period of four, so its flag stays clear
    wr(sa(0, 3), 32'h5);
    wr(sa(0, 4), 32'h3);
    repeat (10) @(posedge sys_clk);
    rd(sa(0, 4));
    chk(q[1:0], 2'b01, "cmp flags");
    for (i = 0; i < 3; i = i + 1) begin
      wr(sa(0, 5), (i + 1) % 3);
      repeat (3) @(posedge sys_clk);
      chk(sm_irq[0], i == 0, "irq enable");
    end
    wr(9'h000, 32'h0);
    // random fault maps on sm1 outputs, random pins
    for (i = 0; i < 8; i = i + 1) begin
      m = 12'($random(seed));
      wr(sa(1, 7), m);
      fault_pin <= 4'($random(seed));
      pwm_in <= 12'($random(seed));
      cap_pin <= 12'($random(seed));
      repeat (6) @(posedge sys_clk);
      exp_out = pwm_in;
      for (t = 0; t < 3; t = t + 1) if ((m[4 * t +: 4] & fault_pin) != 4'h0) exp_out[3 + t] = 1'b0;
      chk(pwm_out, exp_out, "fault force");
      rd(sa(1, 4));
      chk(q[10:8], cap_pin[5:3], "pin level");
    end
    // only fault 0 stays active; its enable alone raises the line
    fault_pin <= 4'h1;
    repeat (6) @(posedge sys_clk);
    wr(9'h004, 32'hf);
    for (i = 0; i < 2; i = i + 1) begin
      wr(9'h008, 2 >> i);
      repeat (3) @(posedge sys_clk);
      chk(fault_irq, i, "fault irq");
    end
    wrap_up;
  end
endmodule
